/* src/ocsp_pkg.sv */
// ----------------------------------------------------------------------
// Shared constants for the single-pulse compare channel
// ----------------------------------------------------------------------
package ocsp_pkg;

  // Data widths
  localparam int TIMER_W = 16;                  // Timer and compare width
  localparam int CTRL_W  = 16;                  // Control register width

  // Channel control register field positions
  localparam int MODE_LSB = 0;                  // Mode field low bit
  localparam int MODE_MSB = 2;                  // Mode field high bit
  localparam int TSEL_BIT = 3;                  // Time base select bit

  // Timer control register field position
  localparam int TIMER_RUN_BIT = 15;            // Timer run enable bit

  // Mode encodings
  localparam logic [2:0] MODE_OFF    = 3'h0;    // Channel disabled
  localparam logic [2:0] MODE_SINGLE = 3'h4;    // Dual compare, one pulse

  // Values after reset
  localparam logic [CTRL_W-1:0]  CTRL_RESET  = 16'h0000;
  localparam logic [TIMER_W-1:0] COUNT_RESET = 16'h0000;
  localparam logic [TIMER_W-1:0] COUNT_ZERO  = 16'h0000;

  // Cycle counts
  localparam int FLAG_DELAY = 2;                // Falling edge to flag

  // Pulse sequencer states
  typedef enum logic [1:0]
  {
    ST_OFF       = 2'b00,                       // Disabled, output low
    ST_WAIT_RISE = 2'b01,                       // Armed, output low
    ST_WAIT_FALL = 2'b10,                       // Output high
    ST_DONE      = 2'b11                        // Pulse finished, low
  } pulse_state_t;

endpackage

/* src/timebase_if.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Link between one time base counter and the compare channel
// ----------------------------------------------------------------------
interface timebase_if;
  import ocsp_pkg::*;

  logic               run;                      // Count enable
  logic               clear;                    // Synchronous count clear
  logic [TIMER_W-1:0] period;                   // Terminal count
  logic [TIMER_W-1:0] count;                    // Present count

  // Counter side
  modport timer
  (
    input  run,
    input  clear,
    input  period,
    output count
  );

  // Channel side
  modport channel
  (
    output run,
    output clear,
    output period,
    input  count
  );
endinterface

/* src/timebase_counter.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Up-counting time base, wraps to zero after its period value
// ----------------------------------------------------------------------
module timebase_counter
(
  // Clock and reset
  input  wire logic   clk_sys_in,
  input  wire logic   srst_in,
  // Counter link
  timebase_if.timer   tb
);
  import ocsp_pkg::*;

  logic [TIMER_W-1:0] count_q;                  // Counter state
  logic [TIMER_W-1:0] count_d;                  // Next count

  // Next count: clear first, then wrap at period, then increment
  always_comb
  begin
    count_d = count_q;
    if (tb.clear)
    begin
      count_d = COUNT_ZERO;
    end
    else if (tb.run)
    begin
      // Zero on the clock after the period match
      if (count_q == tb.period)
      begin
        count_d = COUNT_ZERO;
      end
      else
      begin
        count_d = count_q + 16'h0001;
      end
    end
  end

  // Register only
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      count_q <= COUNT_RESET;
    end
    else
    begin
      count_q <= count_d;
    end
  end

  assign tb.count = count_q;

  // Wrap to zero after reaching the period
  chk_timer_wrap_zero : assert property (
    @(posedge clk_sys_in) disable iff (srst_in)
    (tb.run && !tb.clear && count_q == tb.period) |=> (count_q == COUNT_ZERO))
    else $error("timer did not return to zero after period");

  // Steady increment below the period
  chk_timer_steps_up : assert property (
    @(posedge clk_sys_in) disable iff (srst_in)
    (tb.run && !tb.clear && count_q != tb.period)
      |=> (count_q == $past(count_q) + 16'h0001))
    else $error("timer did not step by one");

endmodule

/* src/compare_single_pulse_channel.sv */
`timescale 1ns/10ps
// What this block does
// - Mode 100 write forces low, arms pulse
// - Mode field sits in control bits 2:0
// - Control bit 3 picks the time base
// - First primary match after arming drives high
// - Secondary match drives low, stays low
// - Secondary match sets flag; enable gates request
// - Rewriting mode 100 re-arms, no timer reset
// - No disable step; control rewrite restarts
// - Works with timer running or stopped
// - Output changes one clock after match
// - Timer counts to period, then zero
// - Flag sets two clocks after falling edge
// - Period below secondary: output stays high
module compare_single_pulse_channel
  import ocsp_pkg::*;
(
  // Clock and reset
  input  wire logic                            clk_sys_in,
  input  wire logic                            srst_in,
  // Channel control register access
  input  wire logic                            ctrl_wr_in,
  input  wire logic [ocsp_pkg::CTRL_W-1:0]     ctrl_wdata_in,
  output logic      [ocsp_pkg::CTRL_W-1:0]     ctrl_rdata_out,
  // Compare values
  input  wire logic [ocsp_pkg::TIMER_W-1:0]    primary_compare_value_in,
  input  wire logic [ocsp_pkg::TIMER_W-1:0]    secondary_compare_value_in,
  // Time bases
  input  wire logic [1:0][ocsp_pkg::CTRL_W-1:0] timer_control_register_in,
  input  wire logic [1:0][ocsp_pkg::TIMER_W-1:0] timer_period_value_in,
  input  wire logic [1:0]                      timer_clear_in,
  output logic      [1:0][ocsp_pkg::TIMER_W-1:0] timer_count_out,
  // Interrupt flag and request
  input  wire logic                            channel_interrupt_enable_in,
  input  wire logic                            flag_clear_in,
  output logic                                 channel_interrupt_flag_out,
  output logic                                 irq_out,
  // Output pin and status
  output logic                                 compare_output_pin_out,
  output logic      [1:0]                      pulse_state_out
);
  import ocsp_pkg::*;

  // --------------------------------------------------------------------
  // Time bases
  // --------------------------------------------------------------------
  timebase_if tb_if [2] ();                     // One link per timer
  logic [1:0][TIMER_W-1:0] count_w;             // Counts seen by channel

  // Two identical counters, run from their own run bits
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_timer
      assign tb_if[gi].run    = timer_control_register_in[gi][TIMER_RUN_BIT];
      assign tb_if[gi].clear  = timer_clear_in[gi];
      assign tb_if[gi].period = timer_period_value_in[gi];
      assign count_w[gi]      = tb_if[gi].count;

      timebase_counter u_timer
      (
        .clk_sys_in (clk_sys_in),
        .srst_in    (srst_in),
        .tb         (tb_if[gi])
      );
    end
  endgenerate

  assign timer_count_out = count_w;

  // --------------------------------------------------------------------
  // Control register and compare matching
  // --------------------------------------------------------------------
  logic [2:0]         mode_q;                   // Channel mode field
  logic [2:0]         mode_d;
  logic               tsel_q;                   // Time base select
  logic               tsel_d;
  logic [TIMER_W-1:0] sel_count;                // Count of chosen timer
  logic               pri_match;                // Count equals primary
  logic               sec_match;                // Count equals secondary
  logic               arm_wr;                   // Write of single mode

  // Chosen time base; a select write takes effect on the next clock
  assign sel_count = tsel_q ? count_w[1] : count_w[0];

  // Plain equality; a secondary beyond the period never matches
  assign pri_match = (sel_count == primary_compare_value_in);
  assign sec_match = (sel_count == secondary_compare_value_in);

  // Arming ignores timer run state, so running or stopped both work
  assign arm_wr = ctrl_wr_in && (ctrl_wdata_in[MODE_MSB:MODE_LSB] == MODE_SINGLE);

  // Next control fields
  always_comb
  begin
    mode_d = mode_q;
    tsel_d = tsel_q;
    if (ctrl_wr_in)
    begin
      mode_d = ctrl_wdata_in[MODE_MSB:MODE_LSB];
      tsel_d = ctrl_wdata_in[TSEL_BIT];
    end
  end

  // Register only; reset leaves the channel off
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      mode_q <= CTRL_RESET[MODE_MSB:MODE_LSB];
      tsel_q <= CTRL_RESET[TSEL_BIT];
    end
    else
    begin
      mode_q <= mode_d;
      tsel_q <= tsel_d;
    end
  end

  // Readback: bits above the time base select read as zero
  always_comb
  begin
    ctrl_rdata_out                    = CTRL_RESET;
    ctrl_rdata_out[MODE_MSB:MODE_LSB] = mode_q;
    ctrl_rdata_out[TSEL_BIT]          = tsel_q;
  end

  // --------------------------------------------------------------------
  // Pulse sequencer
  // --------------------------------------------------------------------
  pulse_state_t state_q;                        // Sequencer state
  pulse_state_t state_d;
  logic         pin_q;                          // Registered output pin
  logic         pin_d;
  logic         fall_now;                       // Falling edge this cycle

  // Next state; a control write always overrides the sequence
  always_comb
  begin
    state_d  = state_q;
    pin_d    = pin_q;
    fall_now = 1'b0;
    if (ctrl_wr_in)
    begin
      if (arm_wr)
      begin
        // Arm or re-arm: no disable, no timer reset needed
        state_d = ST_WAIT_RISE;
        pin_d   = 1'b0;
      end
      else
      begin
        // Other modes belong elsewhere; hold the pin low
        state_d = ST_OFF;
        pin_d   = 1'b0;
      end
    end
    else
    begin
      case (state_q)
        ST_WAIT_RISE:
        begin
          // Registered, so the pin rises one clock after the match
          if (pri_match)
          begin
            state_d = ST_WAIT_FALL;
            pin_d   = 1'b1;
          end
        end
        ST_WAIT_FALL:
        begin
          // Stays high until a secondary match appears
          if (sec_match)
          begin
            state_d  = ST_DONE;
            pin_d    = 1'b0;
            fall_now = 1'b1;
          end
        end
        ST_DONE:
        begin
          // No further pulses until re-armed
          pin_d = 1'b0;
        end
        default:
        begin
          pin_d = 1'b0;
        end
      endcase
    end
  end

  // Register only
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      state_q <= ST_OFF;
      pin_q   <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      pin_q   <= pin_d;
    end
  end

  assign compare_output_pin_out = pin_q;
  assign pulse_state_out        = state_q;

  // --------------------------------------------------------------------
  // Interrupt flag
  // --------------------------------------------------------------------
  logic [FLAG_DELAY-1:0] fall_pipe_q;           // Edge delay line
  logic [FLAG_DELAY-1:0] fall_pipe_d;
  logic                  flag_q;                // Sticky channel flag
  logic                  flag_d;

  // Delay line keeps running across re-arms so no event is dropped
  always_comb
  begin
    fall_pipe_d = {fall_pipe_q[FLAG_DELAY-2:0], fall_now};
    flag_d      = flag_q;
    if (flag_clear_in)
    begin
      flag_d = 1'b0;
    end
    // Set beats a clear in the same cycle
    if (fall_pipe_q[FLAG_DELAY-1])
    begin
      flag_d = 1'b1;
    end
  end

  // Register only
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      fall_pipe_q <= '0;
      flag_q      <= 1'b0;
    end
    else
    begin
      fall_pipe_q <= fall_pipe_d;
      flag_q      <= flag_d;
    end
  end

  assign channel_interrupt_flag_out = flag_q;
  // Request only while enabled
  assign irq_out = flag_q && channel_interrupt_enable_in;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  sequence s_rise_cause;
    state_q == ST_WAIT_RISE && pri_match && !ctrl_wr_in;
  endsequence

  sequence s_fall_cause;
    state_q == ST_WAIT_FALL && sec_match && !ctrl_wr_in;
  endsequence

  chk_arm_forces_low : assert property (
    @(posedge clk_sys_in) disable iff (srst_in)
    arm_wr |=> (!pin_q && state_q == ST_WAIT_RISE))
    else $error("arming did not force the pin low");

  chk_rise_one_clock : assert property (
    @(posedge clk_sys_in) disable iff (srst_in)
    s_rise_cause |-> !pin_q ##1 pin_q)
    else $error("pin did not rise one clock after primary match");

  chk_fall_then_flag : assert property (
    @(posedge clk_sys_in) disable iff (srst_in)
    s_fall_cause |=> !pin_q ##2 flag_q)
    else $error("flag not set two clocks after falling edge");

  chk_done_stays_low : assert property (
    @(posedge clk_sys_in) disable iff (srst_in)
    (state_q == ST_DONE && !ctrl_wr_in) |=> (!pin_q && state_q == ST_DONE))
    else $error("pin left low state without re-arm");

  chk_high_holds : assert property (
    @(posedge clk_sys_in) disable iff (srst_in)
    (state_q == ST_WAIT_FALL && !sec_match && !ctrl_wr_in) |=> pin_q)
    else $error("pin fell without a secondary match");

  chk_irq_gated : assert property (
    @(posedge clk_sys_in) disable iff (srst_in)
    fall_pipe_q[FLAG_DELAY-1] |=> (irq_out == channel_interrupt_enable_in))
    else $error("request does not follow the enable once the flag sets");

  chk_sel_routes : assert property (
    @(posedge clk_sys_in) disable iff (srst_in)
    (ctrl_wr_in && ctrl_wdata_in[TSEL_BIT]) |=> (sel_count == count_w[1]))
    else $error("time base select not honoured");

  chk_reset_clears : assert property (
    @(posedge clk_sys_in) disable iff (srst_in)
    $past(srst_in) |-> (mode_q == MODE_OFF && !pin_q && !flag_q))
    else $error("reset did not clear the channel");

endmodule

/* tb/pulse_sink.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Load on the compare pin: a passive input that tallies edges
// ----------------------------------------------------------------------
module pulse_sink
(
  // Clock
  input  wire logic clk_sys_in,
  // Observed pin
  input  wire logic pin_in,
  // Edge tallies
  output int        rise_count_out,
  output int        fall_count_out
);
  logic pin_q = 1'b0;                           // Pin level one clock ago

  // Count edges; a plain load never drives back, so nothing to release
  always @(posedge clk_sys_in)
  begin
    if (pin_in === 1'b1 && pin_q === 1'b0)
    begin
      rise_count_out <= rise_count_out + 1;
    end
    if (pin_in === 1'b0 && pin_q === 1'b1)
    begin
      fall_count_out <= fall_count_out + 1;
    end
    pin_q <= pin_in;
  end
endmodule

/* tb/compare_single_pulse_channel_tb_top.sv */
`timescale 1ns/10ps
module compare_single_pulse_channel_tb_top;
  import ocsp_pkg::*;
  // ----------------------------------------------------------------------
  // Stimulus, observed outputs and tallies
  // ----------------------------------------------------------------------
  logic                    clk_sys_in = 1'b0;
  logic                    srst_in    = 1'b1;
  logic                    wr         = 1'b0;
  logic [CTRL_W-1:0]       wdata      = 16'h0000;
  logic [TIMER_W-1:0]      pri        = 16'h0005;
  logic [TIMER_W-1:0]      sec        = 16'h0009;
  logic [1:0][CTRL_W-1:0]  tcon       = 32'h0000_0000;
  logic [1:0][TIMER_W-1:0] per        = 32'h0010_0020;
  logic [1:0]              tclr       = 2'h0;
  logic                    ien        = 1'b1;
  logic                    fclr       = 1'b0;
  logic [CTRL_W-1:0]       rdata;
  logic [1:0][TIMER_W-1:0] tcnt;
  logic                    flag;
  logic                    irq;
  logic                    pin;
  logic [1:0]              state;
  int                      rises;
  int                      falls;
  int                      err_count   = 0;
  int                      checks_done = 0;

  always #2 clk_sys_in = ~clk_sys_in;           // 250 MHz

  compare_single_pulse_channel DUT
  (
    .clk_sys_in                 (clk_sys_in),
    .srst_in                    (srst_in),
    .ctrl_wr_in                 (wr),
    .ctrl_wdata_in              (wdata),
    .ctrl_rdata_out             (rdata),
    .primary_compare_value_in   (pri),
    .secondary_compare_value_in (sec),
    .timer_control_register_in  (tcon),
    .timer_period_value_in      (per),
    .timer_clear_in             (tclr),
    .timer_count_out            (tcnt),
    .channel_interrupt_enable_in(ien),
    .flag_clear_in              (fclr),
    .channel_interrupt_flag_out (flag),
    .irq_out                    (irq),
    .compare_output_pin_out     (pin),
    .pulse_state_out            (state)
  );

  pulse_sink sink
  (
    .clk_sys_in    (clk_sys_in),
    .pin_in        (pin),
    .rise_count_out(rises),
    .fall_count_out(falls)
  );

  // ----------------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One-cycle write; flag clear rides along so each pulse starts clean
  task automatic wr_ctrl(input logic [15:0] v);
    @(negedge clk_sys_in);
    wdata = v;
    wr    = 1'b1;
    fclr  = 1'b1;
    @(negedge clk_sys_in);
    wr    = 1'b0;
    fclr  = 1'b0;
  endtask

  // Bounded wait on the pin, sampled at falling edges where it is settled
  task automatic wait_pin(input logic lvl);
    int n;
    n = 0;
    while (pin !== lvl && n < 2000)
    begin
      @(negedge clk_sys_in);
      n++;
    end
    chk("pin level", {15'h0000, lvl}, {15'h0000, pin});
  endtask

  task automatic test_done;
    if (err_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset;
    chk("pin", 16'h0000, {15'h0000, pin});
    chk("flag", 16'h0000, {15'h0000, flag});
    chk("state", 16'h0000, {14'h0000, state});
    chk("rdata", CTRL_RESET, rdata);
  endtask

  // Full pulse on timer s; timer may be stopped or running at arm time
  task automatic t_pulse(input int s, input logic [15:0] cw);
    wr_ctrl(cw);
    chk("rdata", cw, rdata);
    chk("state", 16'h0001, {14'h0000, state});
    chk("pin armed", 16'h0000, {15'h0000, pin});
    tcon[s][TIMER_RUN_BIT] = 1'b1;
    wait_pin(1'b1);
    chk("rise count", pri + 16'h0001, tcnt[s]);
    wait_pin(1'b0);
    chk("fall count", sec + 16'h0001, tcnt[s]);
    @(negedge clk_sys_in);
    chk("flag early", 16'h0000, {15'h0000, flag});
    @(negedge clk_sys_in);
    chk("flag", 16'h0001, {15'h0000, flag});
    chk("irq", {15'h0000, ien}, {15'h0000, irq});
  endtask

  // Timer keeps running past both matches; no second pulse may follow
  task automatic t_one_shot(input int n);
    repeat (80) @(negedge clk_sys_in);
    chk("pin stays low", 16'h0000, {15'h0000, pin});
    chk("state done", 16'h0003, {14'h0000, state});
    chk("rises", 16'(n), 16'(rises));
    chk("falls", 16'(n), 16'(falls));
  endtask

  // Timer returns to zero one clock after reaching its period
  task automatic t_wrap;
    int n;
    n = 0;
    while (tcnt[1] !== per[1] && n < 100)
    begin
      @(negedge clk_sys_in);
      n++;
    end
    @(negedge clk_sys_in);
    chk("wrap count", COUNT_ZERO, tcnt[1]);
  endtask

  // Secondary beyond period: rise only, then mode off drops the pin
  task automatic t_no_fall;
    sec = 16'h0018;
    wr_ctrl(16'h000c);
    wait_pin(1'b1);
    repeat (60) @(negedge clk_sys_in);
    chk("pin held", 16'h0001, {15'h0000, pin});
    chk("no flag", 16'h0000, {15'h0000, flag});
    wr_ctrl(16'h0000);
    chk("pin off", 16'h0000, {15'h0000, pin});
    chk("state off", 16'h0000, {14'h0000, state});
  endtask

  // ----------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (8) @(negedge clk_sys_in);
    srst_in = 1'b0;
    t_reset();
    tclr = 2'h3;
    @(negedge clk_sys_in);
    tclr = 2'h0;
    t_pulse(0, 16'h0004);
    t_one_shot(1);
    ien = 1'b0;
    t_pulse(0, 16'h0004);
    t_one_shot(2);
    tcon[0][TIMER_RUN_BIT] = 1'b0;
    t_pulse(1, 16'h000c);
    t_one_shot(3);
    t_wrap();
    t_no_fall();
    test_done();
  end

  initial
  begin
    #80000;
    err_count++;
    test_done();
  end
endmodule
